// File: atia_pkg.sv
package atia_pkg;

  // Clock and transfer timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int XFER_TIME_NS = 200;
  localparam int XFER_CYCLES = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;

  // Table geometry
  localparam int NUM_PORTS = 4;
  localparam int NUM_ENTRIES = 16;
  localparam int NUM_BYTES = 14;
  localparam int IDX_W = 6;

  // Directly addressed registers
  localparam logic [7:0] REG_TBL_SEL = 8'h6E;
  localparam logic [7:0] REG_IND_OFS = 8'h6F;
  localparam logic [7:0] REG_IND_DATA = 8'hA0;

  // Indirect offsets inside one port's rule space
  localparam logic [7:0] OFS_LAST_BYTE = 8'h0D;
  localparam logic [7:0] OFS_MASK_HI = 8'h10;
  localparam logic [7:0] OFS_MASK_LO = 8'h11;
  localparam logic [7:0] OFS_CTRL = 8'h12;
  localparam logic [3:0] OFS_MODE = 4'h1;

  // Table select register fields
  localparam logic [2:0] TBL_CODE = 3'h2;
  localparam int SEL_CODE_LSB = 5;
  localparam int SEL_DIR_BIT = 4;
  localparam logic [3:0] PORT1_CODE = 4'h1;
  localparam logic [3:0] PORT2_CODE = 4'h2;
  localparam logic [3:0] PORT3_CODE = 4'h3;
  localparam logic [3:0] PORT4_CODE = 4'h5;

  // Access control register fields
  localparam int CTRL_DIR_BIT = 4;
  localparam int MASK_HI_W = 6;
  localparam int MODE_LSB = 4;
  localparam logic [3:0] DONE_RESET = 4'hF;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atia_bus_req_t;

  typedef logic [NUM_BYTES-1:0][7:0] atia_entry_t;

  typedef enum logic [1:0] {ENG_IDLE, ENG_WAIT, ENG_CAPT} atia_eng_t;

  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] ofs;
    logic [7:0] rdata;
    logic [NUM_PORTS-1:0][NUM_BYTES-1:0][7:0] hold;
    logic [NUM_PORTS-1:0][NUM_BYTES-1:0] mask;
    logic [NUM_PORTS-1:0][3:0] entry;
    logic [NUM_PORTS-1:0] dir;
    logic [NUM_PORTS-1:0] rd_done;
    logic [NUM_PORTS-1:0] wr_done;
    logic [NUM_PORTS-1:0][1:0] mode;
    atia_eng_t eng;
    logic [1:0] port;
    logic [CNT_W-1:0] cnt;
  } atia_state_t;

  typedef struct packed {
    logic [NUM_PORTS*NUM_ENTRIES-1:0][NUM_BYTES-1:0][7:0] mem;
    atia_entry_t rdata;
  } atia_tbl_state_t;

  // (RULE14) bit 13 is byte 0
  function automatic logic byte_sel(logic [NUM_BYTES-1:0] mask, int b);
    byte_sel = mask[NUM_BYTES-1-b];
  endfunction

  // Returns {valid, index} for a port code
  function automatic logic [2:0] port_decode(logic [3:0] code);
    case (code)
      PORT1_CODE: port_decode = 3'h4;
      PORT2_CODE: port_decode = 3'h5;
      PORT3_CODE: port_decode = 3'h6;
      PORT4_CODE: port_decode = 3'h7;
      default: port_decode = 3'h0;
    endcase
  endfunction

  // Bursts stop at the control offset so polling needs no rewrite
  function automatic logic [7:0] next_ofs(logic [7:0] ofs);
    next_ofs = (ofs < OFS_CTRL) ? ofs + BYTE_ONE : ofs;
  endfunction

endpackage

// File: atia_table.sv
module atia_table (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Access from the engine
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [atia_pkg::IDX_W-1:0] i_idx,
  input wire logic [atia_pkg::NUM_BYTES-1:0] i_mask,
  input wire atia_pkg::atia_entry_t i_wdata,
  output atia_pkg::atia_entry_t o_rdata
);
  import atia_pkg::*;

  atia_tbl_state_t q;
  atia_tbl_state_t n;

  always_comb
  begin
    n = q;
    if (i_we)
    begin
      for (int b = 0; b < NUM_BYTES; b++)
      begin
        // (RULE10) only masked bytes change
        if (byte_sel(i_mask, b))
          n.mem[i_idx][b] = i_wdata[b];
      end
    end
    if (i_re)
      n.rdata = q.mem[i_idx];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= n;
  end

  assign o_rdata = q.rdata;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_unmasked_keep;
    i_we && !i_mask[NUM_BYTES-1] |=> q.mem[$past(i_idx)][0] == $past(q.mem[i_idx][0]);
  endproperty
  a_unmasked_keep: assert property (p_unmasked_keep) // (RULE14)
    else $error("byte 0 changed with mask bit 13 clear");

  property p_masked_write;
    i_we && i_mask[0] |=> q.mem[$past(i_idx)][NUM_BYTES-1] == $past(i_wdata[NUM_BYTES-1]);
  endproperty
  a_masked_write: assert property (p_masked_write) // (RULE10)
    else $error("byte 13 not written with mask bit 0 set");

endmodule

// File: atia_core.sv
// Function
// (RULE1) Host selects write table with 0x41..0x45
// (RULE2) Host selects read table with 0x51..0x55
// (RULE3) Mask high at 0x10, low 0x11
// (RULE4) Masks 0x3F and 0xFF select all bytes
// (RULE5) Control at 0x12: direction bit, entry number
// (RULE6) Read status bit 5 set on completion
// (RULE7) Write status bit 6 set on completion
// (RULE8) Entry bytes readable at offsets 0x00..0x0D
// (RULE9) Host loads buffer, mask, then control
// (RULE10) Only masked bytes are updated
// (RULE11) Control 0x1F writes buffer to entry 15
// (RULE12) Consecutive indirect accesses auto-increment as burst
// (RULE13) Rule mode held in entry byte 1
// (RULE14) Mask bit 0 is byte 13, reversed
// (RULE15) Select bits 7:5 010 plus port nibble
// (RULE16) Status bits: 0 busy, 1 done, reset 1
// (RULE17) Host avoids triggers while operation in progress
module atia_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire atia_pkg::atia_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // Status
  output logic [atia_pkg::NUM_PORTS-1:0] o_rd_done,
  output logic [atia_pkg::NUM_PORTS-1:0] o_wr_done,
  output logic [atia_pkg::NUM_PORTS-1:0][1:0] o_rule_mode
);
  import atia_pkg::*;

  atia_state_t q;
  atia_state_t n;
  logic [2:0] pd;
  logic [1:0] pi;
  logic sel_ok;
  logic data_wr;
  logic data_rd;
  logic tbl_we;
  logic tbl_re;
  logic [IDX_W-1:0] tbl_idx;
  atia_entry_t tbl_rdata;
  logic [7:0] hold_byte;
  logic start_ok;

  // (RULE15) table code and port nibble
  assign pd = port_decode(q.sel[3:0]);
  assign pi = pd[1:0];
  assign sel_ok = (q.sel[7:SEL_CODE_LSB] == TBL_CODE) && pd[2];
  // Writes need the write select, reads the read select
  assign data_wr = i_bus.wr && (i_bus.addr == REG_IND_DATA) && sel_ok && !q.sel[SEL_DIR_BIT];
  assign data_rd = i_bus.rd && (i_bus.addr == REG_IND_DATA) && sel_ok && q.sel[SEL_DIR_BIT];
  assign hold_byte = (q.ofs <= OFS_LAST_BYTE) ? q.hold[pi][q.ofs[3:0]] : 8'h00;
  // One engine serves all ports; triggers while busy are dropped
  assign start_ok = data_wr && (q.ofs == OFS_CTRL) && (q.eng == ENG_IDLE);
  assign tbl_idx = {q.port, q.entry[q.port]};

  always_comb
  begin
    n = q;
    tbl_we = 1'b0;
    tbl_re = 1'b0;
    if (i_bus.wr)
    begin
      if (i_bus.addr == REG_TBL_SEL)
        n.sel = i_bus.wdata;
      if (i_bus.addr == REG_IND_OFS)
        n.ofs = i_bus.wdata;
    end
    if (data_wr)
    begin
      if (q.ofs <= OFS_LAST_BYTE)
        n.hold[pi][q.ofs[3:0]] = i_bus.wdata;
      // (RULE3) mask byte mapping
      if (q.ofs == OFS_MASK_HI)
        n.mask[pi][NUM_BYTES-1:8] = i_bus.wdata[MASK_HI_W-1:0];
      if (q.ofs == OFS_MASK_LO)
        n.mask[pi][7:0] = i_bus.wdata;
      // (RULE5) entry and direction latch
      if (q.ofs == OFS_CTRL)
      begin
        n.entry[pi] = i_bus.wdata[3:0];
        n.dir[pi] = i_bus.wdata[CTRL_DIR_BIT];
      end
      // (RULE11) trigger on control write
      if (start_ok)
      begin
        n.eng = ENG_WAIT;
        n.port = pi;
        n.cnt = CNT_W'(XFER_CYCLES - 1);
        if (i_bus.wdata[CTRL_DIR_BIT])
          n.wr_done[pi] = 1'b0;
        else
          n.rd_done[pi] = 1'b0;
      end
      // (RULE12) burst advance
      n.ofs = next_ofs(q.ofs);
    end
    if (i_bus.rd)
    begin
      n.rdata = 8'h00;
      if (i_bus.addr == REG_TBL_SEL)
        n.rdata = q.sel;
      if (i_bus.addr == REG_IND_OFS)
        n.rdata = q.ofs;
      if (data_rd)
      begin
        // (RULE8) buffer bytes readback
        if (q.ofs <= OFS_LAST_BYTE)
          n.rdata = hold_byte;
        if (q.ofs == OFS_MASK_HI)
          n.rdata = {2'b00, q.mask[pi][NUM_BYTES-1:8]};
        if (q.ofs == OFS_MASK_LO)
          n.rdata = q.mask[pi][7:0];
        // (RULE16) status bits readback
        if (q.ofs == OFS_CTRL)
          n.rdata = {1'b0, q.wr_done[pi], q.rd_done[pi], q.dir[pi], q.entry[pi]};
        if (!i_bus.wr)
          n.ofs = next_ofs(q.ofs);
      end
    end
    unique case (q.eng)
      ENG_IDLE:
      begin
      end
      ENG_WAIT:
      begin
        if (q.cnt == '0)
        begin
          if (q.dir[q.port])
          begin
            // (RULE7) write done
            tbl_we = 1'b1;
            n.wr_done[q.port] = 1'b1;
            // (RULE13) mode of written entry
            if (byte_sel(q.mask[q.port], int'(OFS_MODE)))
              n.mode[q.port] = q.hold[q.port][OFS_MODE][MODE_LSB+1:MODE_LSB];
            n.eng = ENG_IDLE;
          end
          else
          begin
            tbl_re = 1'b1;
            n.eng = ENG_CAPT;
          end
        end
        else
          n.cnt = q.cnt - CNT_W'(1);
      end
      ENG_CAPT:
      begin
        for (int b = 0; b < NUM_BYTES; b++)
        begin
          // (RULE4) masked bytes loaded to buffer
          if (byte_sel(q.mask[q.port], b))
            n.hold[q.port][b] = tbl_rdata[b];
        end
        if (byte_sel(q.mask[q.port], int'(OFS_MODE)))
          n.mode[q.port] = tbl_rdata[OFS_MODE][MODE_LSB+1:MODE_LSB];
        // (RULE6) read done
        n.rd_done[q.port] = 1'b1;
        n.eng = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.rd_done <= DONE_RESET;
      q.wr_done <= DONE_RESET;
      q.eng <= ENG_IDLE;
    end
    else
      q <= n;
  end

  atia_table u_table (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(tbl_we),
    .i_re(tbl_re),
    .i_idx(tbl_idx),
    .i_mask(q.mask[q.port]),
    .i_wdata(q.hold[q.port]),
    .o_rdata(tbl_rdata)
  );

  assign o_rdata = q.rdata;
  assign o_rd_done = q.rd_done;
  assign o_wr_done = q.wr_done;
  assign o_rule_mode = q.mode;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd_start;
    start_ok && !i_bus.wdata[CTRL_DIR_BIT];
  endsequence
  sequence s_wr_start;
    start_ok && i_bus.wdata[CTRL_DIR_BIT];
  endsequence

  property p_mask_hi;
    data_wr && q.ofs == OFS_MASK_HI |=> q.mask[$past(pi)][13:8] == $past(i_bus.wdata[5:0]);
  endproperty
  a_mask_hi: assert property (p_mask_hi) // (RULE3)
    else $error("mask high byte not stored");

  property p_ctrl_read_dir;
    data_wr && q.ofs == OFS_CTRL && !i_bus.wdata[4] |=> !q.dir[$past(pi)];
  endproperty
  a_ctrl_read_dir: assert property (p_ctrl_read_dir) // (RULE5)
    else $error("read direction not latched");

  property p_ctrl_1f;
    data_wr && q.ofs == OFS_CTRL && i_bus.wdata == 8'h1F
      |=> q.entry[$past(pi)] == 4'hF && q.dir[$past(pi)];
  endproperty
  a_ctrl_1f: assert property (p_ctrl_1f) // (RULE11)
    else $error("0x1F did not select write of entry 15");

  property p_rd_status;
    s_rd_start |=> (!o_rd_done[q.port]) [*5] ##1 o_rd_done[q.port];
  endproperty
  a_rd_status: assert property (p_rd_status) // (RULE6)
    else $error("read status timing wrong");

  property p_wr_status;
    s_wr_start |=> (!o_wr_done[q.port]) [*4] ##1 o_wr_done[q.port];
  endproperty
  a_wr_status: assert property (p_wr_status) // (RULE7)
    else $error("write status timing wrong");

  property p_byte_read;
    data_rd && q.ofs <= OFS_LAST_BYTE |=> o_rdata == $past(hold_byte);
  endproperty
  a_byte_read: assert property (p_byte_read) // (RULE8)
    else $error("entry byte readback wrong");

  property p_burst;
    data_wr && q.ofs < OFS_CTRL |=> q.ofs == $past(q.ofs) + 8'h01;
  endproperty
  a_burst: assert property (p_burst) // (RULE12)
    else $error("offset did not advance in burst");

  property p_bad_sel;
    i_bus.rd && i_bus.addr == REG_IND_DATA && q.sel[7:5] != TBL_CODE |=> o_rdata == 8'h00;
  endproperty
  a_bad_sel: assert property (p_bad_sel) // (RULE15)
    else $error("data read without table select not zero");

  property p_reset_done;
    $past(i_rst) |-> o_rd_done == 4'hF && o_wr_done == 4'hF;
  endproperty
  a_reset_done: assert property (p_reset_done) // (RULE16)
    else $error("status bits not 1 after reset");

  property p_mask_lo;
    data_wr && q.ofs == OFS_MASK_LO |=> q.mask[$past(pi)][7:0] == $past(i_bus.wdata);
  endproperty
  a_mask_lo: assert property (p_mask_lo) // (RULE3)
    else $error("mask low byte not stored");

  // Capture wins over a host byte write in the same cycle
  property p_full_capture;
    q.eng == ENG_CAPT && q.mask[q.port] == 14'h3FFF
      |=> q.hold[$past(q.port)] == $past(tbl_rdata);
  endproperty
  a_full_capture: assert property (p_full_capture) // (RULE4)
    else $error("full mask did not load whole entry");

  property p_byte0_capture;
    q.eng == ENG_CAPT && q.mask[q.port][13] |=> q.hold[$past(q.port)][0] == $past(tbl_rdata[0]);
  endproperty
  a_byte0_capture: assert property (p_byte0_capture) // (RULE14)
    else $error("mask bit 13 did not select byte 0");

  property p_mode_on_write;
    q.eng == ENG_WAIT && q.cnt == '0 && q.dir[q.port] && q.mask[q.port][12]
      |=> o_rule_mode[$past(q.port)] == $past(q.hold[q.port][1][5:4]);
  endproperty
  a_mode_on_write: assert property (p_mode_on_write) // (RULE13)
    else $error("rule mode not taken from written byte 1");

  property p_idle_done;
    q.eng == ENG_IDLE |-> &o_rd_done && &o_wr_done;
  endproperty
  a_idle_done: assert property (p_idle_done) // (RULE16)
    else $error("status bit low with engine idle");

  property p_busy_flag;
    q.eng != ENG_IDLE |-> !(o_rd_done[q.port] && o_wr_done[q.port]);
  endproperty
  a_busy_flag: assert property (p_busy_flag) // (RULE16)
    else $error("busy port shows no operation in progress");

  property p_read_burst;
    data_rd && !i_bus.wr && q.ofs < OFS_CTRL |=> q.ofs == $past(q.ofs) + 8'h01;
  endproperty
  a_read_burst: assert property (p_read_burst) // (RULE12)
    else $error("offset did not advance in read burst");

  property p_bad_port;
    i_bus.wr && i_bus.addr == REG_IND_DATA && q.sel[3:0] == 4'h4 && q.eng != ENG_CAPT
      |=> q.hold == $past(q.hold) && q.mask == $past(q.mask);
  endproperty
  a_bad_port: assert property (p_bad_port) // (RULE15)
    else $error("write with port code 4 changed state");

endmodule

// File: atia_core_bench.sv
module atia_core_bench import atia_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

`define chk(name, exp, got_v) \
  begin \
    tests_run++; \
    if ((got_v) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch %s expected %0h seen %0h", name, exp, got_v); \
    end \
  end

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  atia_bus_req_t bus = '0;
  logic [7:0] rdata;
  logic [NUM_PORTS-1:0] rd_done;
  logic [NUM_PORTS-1:0] wr_done;
  logic [NUM_PORTS-1:0][1:0] rule_mode;
  logic [7:0] got;
  logic [3:0] codes [4] = '{PORT1_CODE, PORT2_CODE, PORT3_CODE, PORT4_CODE};
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  always #25 i_clk = ~i_clk;

  atia_core uut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_bus(bus),
    .o_rdata(rdata),
    .o_rd_done(rd_done),
    .o_wr_done(wr_done),
    .o_rule_mode(rule_mode)
  );

  task automatic close_out();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One-cycle strobes, always launched on a falling edge
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    bus.wr = 1'b1;
    bus.addr = a;
    bus.wdata = d;
    @(negedge i_clk);
    bus.wr = 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    bus.rd = 1'b1;
    bus.addr = a;
    @(negedge i_clk);
    bus.rd = 1'b0;
    @(negedge i_clk);
    d = rdata;
  endtask

  task automatic ind_wr(input logic [7:0] sel, input logic [7:0] ofs, input logic [7:0] d);
    bus_wr(REG_TBL_SEL, sel);
    bus_wr(REG_IND_OFS, ofs);
    bus_wr(REG_IND_DATA, d);
  endtask

  task automatic ind_rd(input logic [7:0] sel, input logic [7:0] ofs, output logic [7:0] d);
    bus_wr(REG_TBL_SEL, sel);
    bus_wr(REG_IND_OFS, ofs);
    bus_rd(REG_IND_DATA, d);
  endtask

  // Bounded poll of one port's status flag
  task automatic wait_done(input int p, input logic is_wr);
    int n;
    n = 0;
    while ((is_wr ? wr_done[p] : rd_done[p]) !== 1'b1 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    `chk("done flag", 1'b1, (is_wr ? wr_done[p] : rd_done[p]));
  endtask

  // Run needs well under 1000 cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    `chk("rd_done", 4'hF, rd_done);
    `chk("wr_done", 4'hF, wr_done);
    `chk("rule_mode", 8'h00, rule_mode);
    ind_rd(8'h55, OFS_CTRL, got);
    `chk("ctrl reset", 8'h60, got);
    // Every port code, both directions; upper mask bits 7:6 read 0
    for (int i = 0; i < 4; i++)
    begin
      ind_wr({TBL_CODE, 1'b0, codes[i]}, OFS_MASK_HI, 8'hC0 | 8'(i + 1));
      ind_rd({TBL_CODE, 1'b1, codes[i]}, OFS_MASK_HI, got);
      `chk("mask hi port", 8'(i + 1), got);
    end
    // Port code 4 writes are refused; port 4 mask keeps its value
    ind_wr(8'h44, OFS_MASK_HI, 8'h2A);
    ind_rd(8'h55, OFS_MASK_HI, got);
    `chk("code 4 refused", 8'h04, got);
    bus_wr(REG_TBL_SEL, 8'h35);
    bus_rd(REG_IND_DATA, got);
    `chk("bad table code", 8'h00, got);
    ind_rd(8'h54, OFS_MASK_HI, got);
    `chk("port code 4", 8'h00, got);
    bus_rd(8'h01, got);
    `chk("unmapped", 8'h00, got);
    // Holding buffer burst, then odd-byte mask, then write entry 15
    bus_wr(REG_TBL_SEL, 8'h45);
    bus_wr(REG_IND_OFS, 8'h00);
    for (int b = 0; b < NUM_BYTES; b++)
      bus_wr(REG_IND_DATA, 8'h10 + 8'(b));
    bus_wr(REG_IND_OFS, OFS_MASK_HI);
    bus_wr(REG_IND_DATA, 8'h15);
    bus_wr(REG_IND_DATA, 8'h55);
    bus_wr(REG_IND_DATA, 8'h1F);
    `chk("wr busy", 1'b0, wr_done[3]);
    wait_done(3, 1'b1);
    ind_rd(8'h55, OFS_MASK_LO, got);
    `chk("mask lo", 8'h55, got);
    ind_rd(8'h55, OFS_CTRL, got);
    `chk("ctrl after write", 8'h7F, got);
    // Full mask, read entry 15 back
    ind_wr(8'h45, OFS_MASK_HI, 8'h3F);
    bus_wr(REG_IND_DATA, 8'hFF);
    bus_wr(REG_IND_DATA, 8'h0F);
    `chk("rd busy", 1'b0, rd_done[3]);
    wait_done(3, 1'b0);
    bus_wr(REG_TBL_SEL, 8'h55);
    bus_wr(REG_IND_OFS, 8'h00);
    for (int b = 0; b < NUM_BYTES; b++)
    begin
      bus_rd(REG_IND_DATA, got);
      `chk("entry byte", (b % 2) ? 8'h10 + 8'(b) : 8'h00, got);
    end
    `chk("rule mode", 2'b01, rule_mode[3]);
    ind_rd(8'h55, OFS_CTRL, got);
    `chk("ctrl after read", 8'h6F, got);
    `chk("other ports idle", 3'h7, {rd_done[2:0]});
    close_out();
  end
endmodule
